// [rtl/lbx_consts.svh]
// constants of the logic and bit operation execute block
// assumes inclusion by bare name from rtl files
`ifndef LBX_CONSTS_SVH
`define LBX_CONSTS_SVH

`define LBX_OP_ADD_RR    8'h02
`define LBX_OP_ADD_RI    8'h03
`define LBX_OP_ADD_GG    8'h04
`define LBX_OP_ADD_GI    8'h05
`define LBX_OP_ADD_IM    8'h06
`define LBX_OP_BOR       8'h07
`define LBX_OP_BCP       8'h17
`define LBX_OP_BTJ       8'h37
`define LBX_OP_AND_RR    8'h52
`define LBX_OP_AND_RI    8'h53
`define LBX_OP_AND_GG    8'h54
`define LBX_OP_AND_GI    8'h55
`define LBX_OP_AND_IM    8'h56
`define LBX_OP_BINV      8'h57
`define LBX_OP_BAND      8'h67
`define LBX_OP_BCLRSET   8'h77

`define LBX_CYC_SHORT    4'h4
`define LBX_CYC_LONG     4'h6
`define LBX_CYC_JUMP     4'ha

`define LBX_IDX_FLAGS    10'h0d5
`define LBX_IDX_STATUS   10'h0d6
`define LBX_IDX_RESULT   10'h0d7
`define LBX_ADDR_FLAGS   {20'h0, `LBX_IDX_FLAGS, 2'b00}
`define LBX_ADDR_STATUS  {20'h0, `LBX_IDX_STATUS, 2'b00}
`define LBX_ADDR_RESULT  {20'h0, `LBX_IDX_RESULT, 2'b00}

`define LBX_FLG_C        7
`define LBX_FLG_Z        6
`define LBX_FLG_S        5
`define LBX_FLG_V        4
`define LBX_FLG_D        3
`define LBX_FLG_H        2
`define LBX_FLAGS_RESET  8'h00

`endif

// [rtl/lbx_pkg.sv]
// types of the logic and bit operation execute block
// assumes nothing beyond the constants header
package lbx_pkg;
  typedef enum logic [1:0] {
    LBX_IDLE = 2'b00,
    LBX_BUSY = 2'b01,
    LBX_DONE = 2'b10
  } lbx_state_t;

  typedef struct packed {
    logic [7:0] dst;
    logic [7:0] flags;
    logic       wr;
    logic       jump;
  } lbx_res_t;
endpackage : lbx_pkg

// [rtl/lbx_alu.sv]
// combinational result of one logic or bit operation
// assumes operands already fetched by the decoder
`timescale 1ns/1ps
`default_nettype none
`include "lbx_consts.svh"
module lbx_alu (
  input  wire logic [7:0]      opcode,
  input  wire logic [7:0]      sel,
  input  wire logic [7:0]      dst_in,
  input  wire logic [7:0]      src_in,
  input  wire logic [7:0]      flags_in,
  output lbx_pkg::lbx_res_t    res
);
  function automatic logic [7:0] lbx_put(input logic [7:0] v,
                                         input logic [2:0] b,
                                         input logic       x);
    logic [7:0] r;
    r    = v;
    r[b] = x;
    return r;
  endfunction : lbx_put

  logic [2:0] b;
  logic       dir;
  logic [8:0] sum;
  logic       bit_r;
  assign b   = sel[3:1];
  assign dir = sel[0];
  assign sum = {1'b0, dst_in} + {1'b0, src_in};

  always_comb begin
    res       = '0;
    res.dst   = dst_in;
    res.flags = flags_in;
    bit_r     = 1'b0;
    case (opcode)
      `LBX_OP_ADD_RR, `LBX_OP_ADD_RI, `LBX_OP_ADD_GG,
      `LBX_OP_ADD_GI, `LBX_OP_ADD_IM: begin
        res.dst = sum[7:0];
        res.wr  = 1'b1;
        res.flags[`LBX_FLG_C] = sum[8];
        res.flags[`LBX_FLG_Z] = (sum[7:0] == 8'h00);
        res.flags[`LBX_FLG_S] = sum[7];
        res.flags[`LBX_FLG_V] = (dst_in[7] == src_in[7])
                                && (sum[7] != dst_in[7]);
        res.flags[`LBX_FLG_D] = 1'b0;
        res.flags[`LBX_FLG_H] = ({1'b0, dst_in[3:0]}
                                 + {1'b0, src_in[3:0]}) > 5'h0f;
      end
      `LBX_OP_AND_RR, `LBX_OP_AND_RI, `LBX_OP_AND_GG,
      `LBX_OP_AND_GI, `LBX_OP_AND_IM: begin
        res.dst = dst_in & src_in;
        res.wr  = 1'b1;
        res.flags[`LBX_FLG_Z] = ((dst_in & src_in) == 8'h00);
        res.flags[`LBX_FLG_S] = dst_in[7] & src_in[7];
        res.flags[`LBX_FLG_V] = 1'b0;
      end
      `LBX_OP_BAND, `LBX_OP_BOR: begin
        // dir 0: dst bit 0 with src bit b; dir 1: dst bit b with src bit 0
        if (!dir) begin
          bit_r = (opcode == `LBX_OP_BAND) ? (dst_in[0] & src_in[b])
                                           : (dst_in[0] | src_in[b]);
          res.dst = lbx_put(dst_in, 3'h0, bit_r);
        end else begin
          bit_r = (opcode == `LBX_OP_BAND) ? (dst_in[b] & src_in[0])
                                           : (dst_in[b] | src_in[0]);
          res.dst = lbx_put(dst_in, b, bit_r);
        end
        res.wr  = 1'b1;
        res.flags[`LBX_FLG_Z] = ~bit_r;
        res.flags[`LBX_FLG_S] = 1'b0;
        res.flags[`LBX_FLG_V] = 1'b0;
      end
      `LBX_OP_BCP: begin
        res.flags[`LBX_FLG_Z] = (dst_in[0] == src_in[b]);
        res.flags[`LBX_FLG_S] = 1'b0;
        res.flags[`LBX_FLG_V] = 1'b0;
      end
      `LBX_OP_BINV: begin
        bit_r   = ~dst_in[b];
        res.dst = lbx_put(dst_in, b, bit_r);
        res.wr  = 1'b1;
        res.flags[`LBX_FLG_Z] = ~bit_r;
        res.flags[`LBX_FLG_S] = 1'b0;
        res.flags[`LBX_FLG_V] = 1'b0;
      end
      `LBX_OP_BCLRSET: begin
        res.dst = lbx_put(dst_in, b, dir);
        res.wr  = 1'b1;
      end
      `LBX_OP_BTJ: begin
        res.jump = ~src_in[b] & ~dir;
      end
      default: begin
        res.wr = 1'b0;
      end
    endcase
  end
endmodule : lbx_alu
`default_nettype wire

// [rtl/lbx_cyc.sv]
// cycle count of each supported opcode
// assumes opcode held stable while it is read
`timescale 1ns/1ps
`default_nettype none
`include "lbx_consts.svh"
module lbx_cyc (
  input  wire logic [7:0] opcode,
  output logic      [3:0] cycles,
  output logic      [1:0] nbytes,
  output logic            known
);
  always_comb begin
    known  = 1'b1;
    cycles = `LBX_CYC_LONG;
    nbytes = 2'h3;
    case (opcode)
      `LBX_OP_AND_RR, `LBX_OP_ADD_RR: begin
        cycles = `LBX_CYC_SHORT;
        nbytes = 2'h2;
      end
      `LBX_OP_AND_RI, `LBX_OP_ADD_RI: nbytes = 2'h2;
      `LBX_OP_AND_GG, `LBX_OP_AND_GI, `LBX_OP_AND_IM,
      `LBX_OP_ADD_GG, `LBX_OP_ADD_GI, `LBX_OP_ADD_IM,
      `LBX_OP_BAND, `LBX_OP_BOR, `LBX_OP_BCP: nbytes = 2'h3;
      `LBX_OP_BINV, `LBX_OP_BCLRSET: begin
        cycles = `LBX_CYC_SHORT;
        nbytes = 2'h2;
      end
      `LBX_OP_BTJ: cycles = `LBX_CYC_JUMP;
      default: begin
        known  = 1'b0;
        cycles = `LBX_CYC_SHORT;
        nbytes = 2'h0;
      end
    endcase
  end
endmodule : lbx_cyc
`default_nettype wire

// [rtl/lbx_exec.sv]
// execute stage for byte add, byte and, and the single-bit operations
// assumes decoder presents operands with a one-cycle issue pulse
// Behaviour
// - add writes dst plus src, source unchanged
// - byte and stores bitwise and in dst
// - and opcodes 52..56 bytes and cycles
// - bit and changes one dst bit only
// - bit or changes one dst bit only
// - second byte: register, bit index, selector
// - selector 0 writes bit0, 1 indexed bit
// - bit and, or, invert: z from result, s cleared
// - bit compare sets z when bits equal
// - bit invert flips indexed bit, 4 cycles
// - opcode 77 selector 0 clears bit
// - opcode 77 selector 1 sets bit
// - bit clear and set keep flags
// - flags register lives at 0d5
// - jump taken only when bit zero
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "lbx_consts.svh"
module lbx_exec (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        issue,
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  sel,
  input  wire logic [7:0]  dst_in,
  input  wire logic [7:0]  src_in,
  output logic             busy,
  output logic             done,
  output logic             wr_en,
  output logic      [7:0]  wr_data,
  output logic             jump,
  output logic             bad_op,
  output logic      [7:0]  status_flags
);
  typedef struct packed {
    lbx_pkg::lbx_state_t st;
    logic                busy;
    logic [3:0]          cnt;
    logic [7:0]          op;
    logic [7:0]          sl;
    logic [7:0]          d;
    logic [7:0]          s;
    logic [7:0]          flags;
    logic                done;
    logic                wr;
    logic [7:0]          wdat;
    logic                jump;
    logic                bad;
    logic                ph_wr;
    logic [31:0]         ph_a;
    logic [31:0]         rdata;
  } lbx_regs_t;

  lbx_regs_t          q;
  lbx_regs_t          next_q;
  lbx_pkg::lbx_res_t  res;
  logic [3:0]         cycles;
  logic               known;
  logic               ap;

  // word address of a register index
  function automatic logic lbx_hit(input logic [31:0] a,
                                   input logic [9:0]  idx);
    return a == {20'h0, idx, 2'b00};
  endfunction : lbx_hit

  lbx_alu u_alu (
    .opcode   (q.op),
    .sel      (q.sl),
    .dst_in   (q.d),
    .src_in   (q.s),
    .flags_in (q.flags),
    .res      (res)
  );

  lbx_cyc u_cyc (
    .opcode (opcode),
    .cycles (cycles),
    .nbytes (),
    .known  (known)
  );

  assign ap = hsel & hready & htrans[1];

  always_comb begin
    next_q      = q;
    next_q.done = 1'b0;
    next_q.wr   = 1'b0;
    next_q.jump = 1'b0;
    next_q.bad  = 1'b0;
    // bus write lands in the data phase
    if (q.ph_wr && lbx_hit(q.ph_a, `LBX_IDX_FLAGS)) begin
      next_q.flags = hwdata[7:0];
    end
    next_q.ph_wr = ap & hwrite;
    next_q.ph_a  = haddr;
    if (ap && !hwrite) begin
      case (haddr)
        `LBX_ADDR_FLAGS:  next_q.rdata = {24'h0, q.flags};
        `LBX_ADDR_STATUS: next_q.rdata = {30'h0, q.st};
        `LBX_ADDR_RESULT: next_q.rdata = {24'h0, q.wdat};
        default:          next_q.rdata = 32'h0;
      endcase
    end
    case (q.st)
      lbx_pkg::LBX_IDLE: begin
        if (issue) begin
          if (known) begin
            next_q.st  = lbx_pkg::LBX_BUSY;
            next_q.cnt = cycles - 4'h2;
            next_q.op  = opcode;
            next_q.sl  = sel;
            next_q.d   = dst_in;
            next_q.s   = src_in;
          end else begin
            next_q.bad = 1'b1;
          end
        end
      end
      lbx_pkg::LBX_BUSY: begin
        if (q.cnt == 4'h0) begin
          next_q.st = lbx_pkg::LBX_DONE;
        end else begin
          next_q.cnt = q.cnt - 4'h1;
        end
      end
      lbx_pkg::LBX_DONE: begin
        // single commit point
        next_q.st    = lbx_pkg::LBX_IDLE;
        next_q.done  = 1'b1;
        next_q.wr    = res.wr;
        next_q.wdat  = res.dst;
        next_q.jump  = res.jump;
        next_q.flags = res.flags;
      end
      default: next_q.st = lbx_pkg::LBX_IDLE;
    endcase
    next_q.busy = (next_q.st != lbx_pkg::LBX_IDLE);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q       <= '0;
      q.flags <= `LBX_FLAGS_RESET;
    end else begin
      q <= next_q;
    end
  end

  assign hrdata       = q.rdata;
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign busy         = q.busy;
  assign done         = q.done;
  assign wr_en        = q.wr;
  assign wr_data      = q.wdat;
  assign jump         = q.jump;
  assign bad_op       = q.bad;
  assign status_flags = q.flags;

  sequence s_take_and;
    q.st == lbx_pkg::LBX_IDLE && issue && opcode == `LBX_OP_AND_RR;
  endsequence

  sequence s_take_band;
    q.st == lbx_pkg::LBX_IDLE && issue && opcode == `LBX_OP_BAND;
  endsequence

  // done is seen on the commit edge, together with wr_en, wr_data and the flags
  property p_and_cycles;
    @(posedge hclk) disable iff (!hresetn)
    s_take_and |=> !done[*4] ##1 done;
  endproperty
  a_and_cycles: assert property (p_and_cycles)
    else $error("and 52 not done after 4 cycles");

  property p_long_cycles;
    @(posedge hclk) disable iff (!hresetn)
    s_take_band |=> !done[*6] ##1 done;
  endproperty
  a_long_cycles: assert property (p_long_cycles)
    else $error("bit and not done after 6 cycles");

  property p_and_result;
    @(posedge hclk) disable iff (!hresetn)
    (q.st == lbx_pkg::LBX_DONE && q.op == `LBX_OP_AND_RR)
      |=> wr_en && wr_data == (q.d & q.s) && !status_flags[`LBX_FLG_V];
  endproperty
  a_and_result: assert property (p_and_result)
    else $error("and result or overflow wrong");

  property p_add_result;
    @(posedge hclk) disable iff (!hresetn)
    (q.st == lbx_pkg::LBX_DONE && q.op == `LBX_OP_ADD_IM)
      |=> wr_data == $past(q.d) + $past(q.s);
  endproperty
  a_add_result: assert property (p_add_result)
    else $error("add result wrong");

  property p_clr_flags;
    @(posedge hclk) disable iff (!hresetn)
    (q.st == lbx_pkg::LBX_DONE && q.op == `LBX_OP_BCLRSET && !q.ph_wr)
      |=> status_flags == $past(status_flags);
  endproperty
  a_clr_flags: assert property (p_clr_flags)
    else $error("bit clear or set changed flags");

  property p_bcp_z;
    @(posedge hclk) disable iff (!hresetn)
    (q.st == lbx_pkg::LBX_DONE && q.op == `LBX_OP_BCP)
      |=> !wr_en && status_flags[`LBX_FLG_Z] == ($past(q.d[0])
          == $past(q.s[q.sl[3:1]]));
  endproperty
  a_bcp_z: assert property (p_bcp_z)
    else $error("bit compare zero flag wrong");

  property p_set_bit;
    @(posedge hclk) disable iff (!hresetn)
    (q.st == lbx_pkg::LBX_DONE && q.op == `LBX_OP_BCLRSET)
      |=> wr_data[$past(q.sl[3:1])] == $past(q.sl[0]);
  endproperty
  a_set_bit: assert property (p_set_bit)
    else $error("indexed bit not cleared or set");

  property p_jump;
    @(posedge hclk) disable iff (!hresetn)
    jump |-> $past(q.op) == `LBX_OP_BTJ && !$past(q.s[q.sl[3:1]]);
  endproperty
  a_jump: assert property (p_jump)
    else $error("jump without a zero bit");

  property p_once;
    @(posedge hclk) disable iff (!hresetn)
    done |=> !done;
  endproperty
  a_once: assert property (p_once)
    else $error("result committed twice");

  property p_refused;
    @(posedge hclk) disable iff (!hresetn)
    (q.st == lbx_pkg::LBX_IDLE && issue && !known) |=> bad_op && !busy;
  endproperty
  a_refused: assert property (p_refused)
    else $error("unknown opcode not refused");

  property p_hold_ops;
    @(posedge hclk) disable iff (!hresetn)
    busy |=> q.op == $past(q.op) && q.d == $past(q.d);
  endproperty
  a_hold_ops: assert property (p_hold_ops)
    else $error("operands changed while busy");

  // a commit in the same cycle wins over the bus write
  property p_flags_write;
    @(posedge hclk) disable iff (!hresetn)
    (q.ph_wr && lbx_hit(q.ph_a, `LBX_IDX_FLAGS)
     && q.st != lbx_pkg::LBX_DONE)
      |=> status_flags == $past(hwdata[7:0]);
  endproperty
  a_flags_write: assert property (p_flags_write)
    else $error("flags write did not land");

  property p_flags_read;
    @(posedge hclk) disable iff (!hresetn)
    (hsel && hready && htrans[1] && !hwrite
     && lbx_hit(haddr, `LBX_IDX_FLAGS))
      |=> hrdata == {24'h0, $past(status_flags)};
  endproperty
  a_flags_read: assert property (p_flags_read)
    else $error("flags read data wrong");

  property p_and_flags;
    @(posedge hclk) disable iff (!hresetn)
    (q.st == lbx_pkg::LBX_DONE && q.op inside {`LBX_OP_AND_RR,
      `LBX_OP_AND_RI, `LBX_OP_AND_GG, `LBX_OP_AND_GI, `LBX_OP_AND_IM})
      |=> status_flags[`LBX_FLG_S] == wr_data[7]
          && status_flags[`LBX_FLG_Z] == (wr_data == 8'h00)
          && status_flags[`LBX_FLG_C] == $past(q.flags[`LBX_FLG_C]);
  endproperty
  a_and_flags: assert property (p_and_flags)
    else $error("and flags wrong");

  property p_bit_one;
    @(posedge hclk) disable iff (!hresetn)
    (q.st == lbx_pkg::LBX_DONE
     && (q.op == `LBX_OP_BAND || q.op == `LBX_OP_BOR))
      |=> wr_en && $countones(wr_data ^ $past(q.d)) <= 1;
  endproperty
  a_bit_one: assert property (p_bit_one)
    else $error("bit op changed more than one bit");

  property p_inv_bit;
    @(posedge hclk) disable iff (!hresetn)
    (q.st == lbx_pkg::LBX_DONE && q.op == `LBX_OP_BINV)
      |=> wr_data == ($past(q.d) ^ (8'h01 << $past(q.sl[3:1])))
          && !status_flags[`LBX_FLG_S];
  endproperty
  a_inv_bit: assert property (p_inv_bit)
    else $error("bit invert result wrong");
endmodule : lbx_exec
`default_nettype wire

// [tb/lbx_core_model.sv]
// core-side model: issues one instruction for each go request
// assumes one clock and the issue contract of the execute block
`timescale 1ns/1ps
`default_nettype none
module lbx_core_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        go,
  input  wire logic [1:0]  gap,
  input  wire logic [31:0] word,
  input  wire logic        fin,
  output logic             issue,
  output logic      [31:0] ops
);
  logic [1:0] cnt;
  logic       act;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      issue <= 1'b0;
      act   <= 1'b0;
      cnt   <= 2'h0;
      ops   <= 32'h0;
    end else begin
      issue <= 1'b0;
      if (go) begin
        act <= 1'b1;
        cnt <= gap;
      end else if (act && cnt != 2'h0) begin
        cnt <= cnt - 2'h1;
      end else if (act) begin
        act   <= 1'b0;
        issue <= 1'b1;
        ops   <= word;
      end else if (fin) begin
        // released operands show the inverse, not the old value
        ops <= ~ops;
      end
    end
  end
endmodule : lbx_core_model
`default_nettype wire

// [tb/logic_and_bit_op_execute_tb.sv]
// bench: corner and random instructions, flag register over the bus
// assumes lbx_exec, lbx_core_model and the constants header
`timescale 1ns/1ps
`default_nettype none
`include "lbx_consts.svh"
module logic_and_bit_op_execute_tb;
  logic        hclk = 1'b0;
  logic        hresetn, hsel, hwrite, go, issue, busy, done;
  logic        wr_en, jump, bad_op, hreadyout, hresp;
  logic [1:0]  htrans, gap;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, word, ops, iss_at, rd;
  logic [31:0] cnt = 32'h0;
  logic [7:0]  wr_data, status_flags, flg, op;
  logic [15:0] lfsr = 16'h0050;
  int          err_total = 0;
  int          comparisons = 0;
  logic [7:0]  tab [16] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h17,
    8'h37, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57, 8'h67, 8'h77};

  always #25 hclk = ~hclk;

  lbx_exec dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .issue(issue), .opcode(ops[31:24]), .sel(ops[23:16]), .dst_in(ops[15:8]),
    .src_in(ops[7:0]), .busy(busy), .done(done), .wr_en(wr_en),
    .wr_data(wr_data), .jump(jump), .bad_op(bad_op),
    .status_flags(status_flags));
  lbx_core_model core_u (.hclk(hclk), .hresetn(hresetn), .go(go), .gap(gap),
    .word(word), .fin(done | bad_op), .issue(issue), .ops(ops));

  always @(posedge hclk) begin
    if (issue && !busy) iss_at <= cnt;
    cnt <= cnt + 32'h1;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction : rnd

  function automatic logic [31:0] cyc_of(input logic [7:0] o);
    case (o)
      8'h02, 8'h52, 8'h57, 8'h77: return 32'h4;
      8'h37: return 32'ha;
      8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h17: return 32'h6;
      8'h53, 8'h54, 8'h55, 8'h56, 8'h67: return 32'h6;
      default: return 32'h0;
    endcase
  endfunction : cyc_of

  // {write, result, flags, jump}
  function automatic logic [17:0] model(input logic [7:0] o, sl, d, s, f);
    logic [8:0] sm;
    logic [7:0] r;
    logic [7:0] nf;
    logic [2:0] b;
    logic       wr;
    logic       j;
    logic       t;
    logic       u;
    b  = sl[3:1];
    r  = d;
    nf = f;
    wr = 1'b1;
    j  = 1'b0;
    t  = sl[0] ? d[b] : d[0];
    u  = sl[0] ? s[0] : s[b];
    sm = {1'b0, d} + {1'b0, s};
    case (o)
      8'h02, 8'h03, 8'h04, 8'h05, 8'h06: begin
        r  = sm[7:0];
        nf = {sm[8], r == 8'h00, r[7], d[7] == s[7] && r[7] != d[7], 1'b0,
              ({1'b0, d[3:0]} + {1'b0, s[3:0]}) > 5'h0f, 2'b00};
      end
      8'h52, 8'h53, 8'h54, 8'h55, 8'h56: begin
        r  = d & s;
        nf = {f[7], r == 8'h00, r[7], 1'b0, f[3:2], 2'b00};
      end
      8'h07, 8'h67: begin
        t  = (o == 8'h67) ? t & u : t | u;
        r[sl[0] ? b : 3'h0] = t;
        nf = {f[7], ~t, 2'b00, f[3:2], 2'b00};
      end
      8'h17: begin
        wr = 1'b0;
        nf = {f[7], d[0] == s[b], 2'b00, f[3:2], 2'b00};
      end
      8'h57: begin
        r[b] = ~d[b];
        nf   = {f[7], d[b], 2'b00, f[3:2], 2'b00};
      end
      8'h77: r[b] = sl[0];
      default: begin
        wr = 1'b0;
        j  = o == 8'h37 && !sl[0] && !s[b];
      end
    endcase
    return {wr, r, nf, j};
  endfunction : model

  task automatic ahb(input logic w, input logic [31:0] a, d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask : ahb

  task automatic run(input logic [7:0] o, sl, d, s);
    logic [17:0] e;
    int          n;
    e = model(o, sl, d, s, flg);
    n = 0;
    @(posedge hclk);
    word <= {o, sl, d, s};
    gap  <= lfsr[1:0];
    go   <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    while ((done | bad_op) !== 1'b1 && n < 40) begin
      @(posedge hclk);
      #1;
      n++;
      if (done !== 1'b1) chk("early flags", {24'h0, status_flags}, {24'h0, flg});
    end
    chk("bad_op", {31'h0, bad_op}, {31'h0, cyc_of(o) == 32'h0});
    chk("wr_en", {31'h0, wr_en}, {31'h0, e[17]});
    if (e[17]) chk("wr_data", {24'h0, wr_data}, {24'h0, e[16:9]});
    chk("flags", {24'h0, status_flags}, {24'h0, e[8:1]});
    chk("jump", {31'h0, jump}, {31'h0, e[0]});
    if (cyc_of(o) != 32'h0) chk("cycles", cnt - iss_at - 32'h1, cyc_of(o));
    flg = e[8:1];
  endtask : run

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  initial begin
    repeat (20000) @(posedge hclk);
    err_total++;
    $display("watchdog expired");
    results();
  end

  initial begin
    {hresetn, hsel, hwrite, go} = 4'h0;
    htrans = 2'b00;
    gap    = 2'b00;
    hsize  = 3'b010;
    haddr  = 32'h0;
    hwdata = 32'h0;
    word   = 32'h0;
    flg    = 8'h00;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, `LBX_ADDR_FLAGS, 32'h0);
    chk("flags reset", rd, 32'h0);
    $display("test reset done");
    run(8'h02, 8'h00, 8'h12, 8'h03);
    run(8'h52, 8'h00, 8'h12, 8'h03);
    run(8'h67, 8'h02, 8'h07, 8'h05);
    run(8'h07, 8'h05, 8'h03, 8'h07);
    run(8'h17, 8'h02, 8'h07, 8'h01);
    run(8'h57, 8'h02, 8'h07, 8'h00);
    run(8'h77, 8'h02, 8'h07, 8'h00);
    run(8'h77, 8'h07, 8'h07, 8'h00);
    ahb(1'b0, `LBX_ADDR_RESULT, 32'h0);
    chk("result reg", rd, 32'h0000_000f);
    ahb(1'b0, `LBX_ADDR_STATUS, 32'h0);
    chk("status reg", rd, 32'h0);
    run(8'h37, 8'h06, 8'h00, 8'h07);
    run(8'h27, 8'h00, 8'h00, 8'h00);
    $display("test corners done");
    for (int i = 0; i < 16; i++) begin
      for (int k = 0; k < 12; k++) begin
        ahb(1'b1, `LBX_ADDR_FLAGS, {24'h0, rnd() & 8'hfc});
        flg = hwdata[7:0];
        if (k == 0) begin
          ahb(1'b0, `LBX_ADDR_FLAGS, 32'h0);
          chk("flags read", rd, {24'h0, flg});
        end
        op = tab[i];
        run(op, (op == 8'h17 || op == 8'h57) ? rnd() & 8'hfe : rnd(), rnd(), rnd());
      end
    end
    $display("test random done");
    ahb(1'b1, 32'h000000d4, 32'h000000ff);
    ahb(1'b0, 32'h000000d4, 32'h0);
    chk("unmapped", rd, 32'h0);
    ahb(1'b0, `LBX_ADDR_FLAGS, 32'h0);
    chk("flags kept", rd, {24'h0, flg});
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    flg = 8'h00;
    ahb(1'b0, `LBX_ADDR_FLAGS, 32'h0);
    chk("flags rereset", rd, 32'h0);
    run(8'h57, 8'h00, 8'h01, 8'h00);
    $display("test bus and reset done");
    results();
  end
endmodule : logic_and_bit_op_execute_tb
`default_nettype wire
